// ===== ccr_codec_end.sv
/*
 Codec end: shifts bytes in on the link clock, checks the address byte,
 and hands each completed byte to the system clock domain by a toggle
 where it is routed into the setting registers.
 Assumes the link clock only runs during bytes from the controller.
*/
`timescale 1ns/100ps
module ccr_codec_end
    import ccr_pkg::*;
#(
    parameter logic [5:0] DEV_ADDR = CCR_DEV_ADDR
)
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    ccr_link_if.codec link,
    // Decoded settings
    output logic [1:0] master_clock_ratio,
    output logic [2:0] data_format,
    output logic offset_removal_enable,
    output logic [5:0] output_attenuation,
    output logic [4:0] low_shelf_gain,
    output logic [2:0] high_shelf_gain,
    output logic [1:0] emphasis_curve,
    output logic silence_enable,
    output logic tone_set_select_hi,
    output logic tone_set_select_lo,
    output logic [1:0] converter_power_gate,
    output logic adc_power_on,
    output logic dac_power_on,
    output logic full_attenuation
);
    // Link domain: shifter clocked by the controller's shift clock
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] byte_reg;
    logic byte_is_addr_reg;
    logic byte_tgl_reg;
    wire [7:0] shift_next = {link.ctrl_serial_line, shift_reg[7:1]};
    always_ff @(posedge link.ctrl_shift_clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            byte_reg <= 8'h00;
            byte_is_addr_reg <= 1'b0;
            byte_tgl_reg <= 1'b0;
        end
        else
        begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
                byte_reg <= shift_next;
                byte_is_addr_reg <= ~link.ctrl_phase_line;
                byte_tgl_reg <= ~byte_tgl_reg;
            end
        end
    end

    // Crossing: byte and flag stay stable until the next byte ends
    logic [2:0] tgl_sync_reg;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            tgl_sync_reg <= 3'h0;
        else
            tgl_sync_reg <= {tgl_sync_reg[1:0], byte_tgl_reg};
    end
    wire byte_done = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    // A new byte needs eight link edges, far longer than the three-flop delay

    // Address handling
    logic selected_reg;
    logic [1:0] xfer_type_reg;
    wire addr_match = (byte_reg[7:2] == DEV_ADDR);
    wire addr_byte = byte_done & byte_is_addr_reg;
    wire data_byte = byte_done & ~byte_is_addr_reg & selected_reg;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            selected_reg <= 1'b0;
            xfer_type_reg <= CCR_XFER_DATA;
        end
        else if (addr_byte)
        begin
            selected_reg <= addr_match;
            xfer_type_reg <= byte_reg[1:0];
        end
    end

    // Routing; unused types write nothing
    // Types 01 and 11 keep the codec selected but route nowhere
    wire is_status = (xfer_type_reg == CCR_XFER_STATUS);
    wire is_data = (xfer_type_reg == CCR_XFER_DATA);
    wire [1:0] sel = byte_reg[7:6];
    wire wr_setup = data_byte & is_status & (sel == 2'h0);
    wire wr_atten = data_byte & is_data & (sel == CCR_SEL_VOLUME);
    wire wr_tone = data_byte & is_data & (sel == CCR_SEL_TONE);
    wire wr_emph = data_byte & is_data & (sel == CCR_SEL_EMPH) & ~byte_reg[5];
    wire wr_power = data_byte & is_data & (sel == CCR_SEL_POWER)
        & (byte_reg[5:2] == 4'h0);

    logic [5:0] setup_reg;
    logic [5:0] atten_reg;
    logic [5:0] tone_reg;
    logic [4:0] emph_reg;
    logic [1:0] power_reg;
    // Registers hold between writes
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            setup_reg <= CCR_RST_SETUP;
            atten_reg <= CCR_RST_ATTEN;
            tone_reg <= CCR_RST_TONE;
            emph_reg <= CCR_RST_EMPH;
            power_reg <= CCR_RST_POWER;
        end
        else
        begin
            if (wr_setup)
                setup_reg <= byte_reg[5:0];
            if (wr_atten)
                atten_reg <= byte_reg[5:0];
            if (wr_tone)
                tone_reg <= byte_reg[5:0];
            if (wr_emph)
                emph_reg <= byte_reg[4:0];
            if (wr_power)
                power_reg <= byte_reg[1:0];
        end
    end

    // Gains and the floor flag are registered so data pins come from flops
    // Costs one cycle, still inside the controller's return to idle
    wire [4:0] low_gain_next;
    wire [2:0] high_gain_next;
    logic [4:0] low_gain_reg;
    logic [2:0] high_gain_reg;
    logic full_att_reg;
    wire full_att_next = (atten_reg == CCR_ATTEN_FULL);
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // Reset tone set is flat, so both gains start at zero
            low_gain_reg <= 5'h00;
            high_gain_reg <= 3'h0;
            full_att_reg <= (CCR_RST_ATTEN == CCR_ATTEN_FULL);
        end
        else
        begin
            low_gain_reg <= low_gain_next;
            high_gain_reg <= high_gain_next;
            full_att_reg <= full_att_next;
        end
    end

    assign master_clock_ratio = setup_reg[5:4];
    assign data_format = setup_reg[3:1];
    assign offset_removal_enable = setup_reg[0];
    assign output_attenuation = atten_reg;
    assign full_attenuation = full_att_reg;
    assign low_shelf_gain = low_gain_reg;
    assign high_shelf_gain = high_gain_reg;
    assign emphasis_curve = emph_reg[4:3];
    assign silence_enable = emph_reg[2];
    assign tone_set_select_hi = emph_reg[1];
    assign tone_set_select_lo = emph_reg[0];
    assign converter_power_gate = power_reg;
    assign adc_power_on = power_reg[1];
    assign dac_power_on = power_reg[0];

    ccr_gain_map u_gain
    (
        .low_code(tone_reg[5:2]),
        .high_code(tone_reg[1:0]),
        .mode_code(emph_reg[1:0]),
        .low_shelf_db(low_gain_next),
        .high_shelf_db(high_gain_next),
        .tone_set()
    );
endmodule // ccr_codec_end

// ===== ccr_pkg.sv
/*
 Package for the codec control register decoder: device address, reset values, codes,
 transfer types for the codec end, and timing constants for the controller end of the link.
 Assumes nothing of its surroundings.
*/
package ccr_pkg;
    localparam int CCR_BYTE_W = 8;
    localparam logic [5:0] CCR_DEV_ADDR = 6'h2a; // Arbitrary value
    localparam logic [1:0] CCR_XFER_DATA = 2'h0;
    localparam logic [1:0] CCR_XFER_STATUS = 2'h2;
    localparam logic [1:0] CCR_SEL_VOLUME = 2'h0;
    localparam logic [1:0] CCR_SEL_TONE = 2'h1;
    localparam logic [1:0] CCR_SEL_EMPH = 2'h2;
    localparam logic [1:0] CCR_SEL_POWER = 2'h3;
    localparam logic [1:0] CCR_RATIO_512 = 2'h0;
    localparam logic [1:0] CCR_RATIO_384 = 2'h1;
    localparam logic [1:0] CCR_RATIO_256 = 2'h2;
    localparam logic [5:0] CCR_ATTEN_FULL = 6'h3f;
    localparam logic [4:0] CCR_BASS_MIN_CAP = 5'h12;
    localparam logic [4:0] CCR_BASS_MAX_CAP = 5'h18;
    localparam logic [5:0] CCR_RST_SETUP = 6'h00;
    localparam logic [5:0] CCR_RST_ATTEN = 6'h00;
    localparam logic [5:0] CCR_RST_TONE = 6'h00;
    localparam logic [4:0] CCR_RST_EMPH = 5'h00;
    localparam logic [1:0] CCR_RST_POWER = 2'h3;
    localparam int CCR_LINK_DIV = 4;
    localparam int CCR_GAP_CYC = 8;
    typedef enum logic [1:0] {CCR_TONE_FLAT, CCR_TONE_MIN, CCR_TONE_MAX} ccr_tone_e;
endpackage

// ===== ccr_link_if.sv
/*
 Three-wire control link between the controller end and the codec end.
 Assumes the controller makes all three wires, codec only listens.
*/
`timescale 1ns/100ps
interface ccr_link_if;
    logic ctrl_shift_clock;
    logic ctrl_serial_line;
    logic ctrl_phase_line;
    modport ctrl (output ctrl_shift_clock, output ctrl_serial_line, output ctrl_phase_line);
    modport codec (input ctrl_shift_clock, input ctrl_serial_line, input ctrl_phase_line);
endinterface

// ===== ccr_gain_map.sv
/*
 Tone gain mapper: bass and treble codes to dB per selected gain set.
 Assumes settled register inputs in the system clock domain.
*/
`timescale 1ns/100ps
module ccr_gain_map
    import ccr_pkg::*;
(
    // Codes
    input wire logic [3:0] low_code,
    input wire logic [1:0] high_code,
    input wire logic [1:0] mode_code,
    // Gains in dB and the chosen tone set
    output logic [4:0] low_shelf_db,
    output logic [2:0] high_shelf_db,
    output ccr_tone_e tone_set
);
    wire [4:0] raw_db = {low_code, 1'b0};
    wire [4:0] min_db = (raw_db > CCR_BASS_MIN_CAP) ? CCR_BASS_MIN_CAP : raw_db;
    wire [4:0] max_db = (raw_db > CCR_BASS_MAX_CAP) ? CCR_BASS_MAX_CAP : raw_db;
    // Codes 01 and 10 both select min
    assign tone_set = (mode_code == 2'h0) ? CCR_TONE_FLAT :
        (mode_code == 2'h3) ? CCR_TONE_MAX : CCR_TONE_MIN;
    assign low_shelf_db = (tone_set == CCR_TONE_FLAT) ? 5'h00 :
        (tone_set == CCR_TONE_MIN) ? min_db : max_db;
    assign high_shelf_db = (tone_set == CCR_TONE_FLAT) ? 3'h0 : {high_code, 1'b0};
endmodule // ccr_gain_map

// ===== ccr_ctrl_end.sv
/*
 Controller end: sends an address byte then one data byte, LSB first,
 making the shift clock by dividing the system clock.
 Assumes the user holds the request fields until ready returns.
*/
`timescale 1ns/100ps
module ccr_ctrl_end
    import ccr_pkg::*;
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // User request
    input wire logic req_valid,
    input wire logic [5:0] req_addr,
    input wire logic [1:0] req_type,
    input wire logic [7:0] req_data,
    output logic req_ready,
    // Link
    ccr_link_if.ctrl link
);
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_GAP, ST_DATA} ccr_ctl_state_e;
    ccr_ctl_state_e state_reg;
    logic [7:0] sh_reg;
    logic [7:0] data_reg;
    logic [2:0] bit_reg;
    logic [3:0] div_reg;
    logic clk_reg;
    logic phase_reg;
    wire half = (div_reg == 4'(CCR_LINK_DIV - 1));
    wire last_bit = (bit_reg == 3'h7);
    assign req_ready = (state_reg == ST_IDLE);
    assign link.ctrl_shift_clock = clk_reg;
    assign link.ctrl_serial_line = sh_reg[0];
    assign link.ctrl_phase_line = phase_reg;
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            sh_reg <= 8'h00;
            data_reg <= 8'h00;
            bit_reg <= 3'h0;
            div_reg <= 4'h0;
            clk_reg <= 1'b0;
            phase_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                begin
                    div_reg <= 4'h0;
                    clk_reg <= 1'b0;
                    if (req_valid)
                    begin
                        sh_reg <= {req_addr, req_type};
                        data_reg <= req_data;
                        phase_reg <= 1'b0;
                        bit_reg <= 3'h0;
                        state_reg <= ST_ADDR;
                    end
                end
                ST_ADDR, ST_DATA:
                begin
                    div_reg <= half ? 4'h0 : div_reg + 4'h1;
                    if (half)
                        clk_reg <= ~clk_reg;
                    // Shift after the rising edge has sampled the bit
                    if (half & clk_reg)
                    begin
                        sh_reg <= {1'b0, sh_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (last_bit)
                        begin
                            div_reg <= 4'h0;
                            state_reg <= (state_reg == ST_ADDR) ? ST_GAP : ST_IDLE;
                        end
                    end
                end
                ST_GAP:
                begin
                    div_reg <= div_reg + 4'h1;
                    if (div_reg == 4'(CCR_GAP_CYC - 1))
                    begin
                        phase_reg <= 1'b1;
                        sh_reg <= data_reg;
                        div_reg <= 4'h0;
                        state_reg <= ST_DATA;
                    end
                end
            endcase
        end
    end
endmodule // ccr_ctrl_end

// ===== ccr_link_props.sv
/*
 Wire checks on the control link between the two ends.
 Assumes the controller end drives all wires from ref_clk registers.
*/
`timescale 1ns/100ps
module ccr_link_props
    import ccr_pkg::*;
(
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link wires
    input wire logic ctrl_shift_clock,
    input wire logic ctrl_serial_line,
    input wire logic ctrl_phase_line
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic clk_q_reg;
    logic phase_q_reg;
    logic [3:0] bits_reg;
    logic [3:0] bits_next;
    wire rise = ctrl_shift_clock && !clk_q_reg;
    wire swap = ctrl_phase_line != phase_q_reg;
    // Bits counted per phase, so a short byte shows at the phase change
    assign bits_next = swap ? {3'h0, rise} : bits_reg + {3'h0, rise};
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            clk_q_reg <= 1'b0;
            phase_q_reg <= 1'b0;
            bits_reg <= 4'h0;
        end
        else
        begin
            clk_q_reg <= ctrl_shift_clock;
            phase_q_reg <= ctrl_phase_line;
            bits_reg <= bits_next;
        end
    end
    AST_HIGH_LEN: assert property ($rose(ctrl_shift_clock) |->
        ctrl_shift_clock [*4] ##1 !ctrl_shift_clock) else $error("shift clock high time");
    AST_LOW_LEN: assert property ($fell(ctrl_shift_clock) |->
        (!ctrl_shift_clock) [*4]) else $error("shift clock low time");
    AST_SETUP: assert property ($rose(ctrl_shift_clock) |->
        $stable(ctrl_serial_line)) else $error("data moved at rising edge");
    AST_BIT_HOLD: assert property (ctrl_shift_clock && clk_q_reg |->
        $stable(ctrl_serial_line)) else $error("data moved while clock high");
    AST_PHASE_HOLD: assert property (swap |->
        !ctrl_shift_clock && !clk_q_reg) else $error("phase moved near clock");
    AST_ADDR_LEN: assert property ($rose(ctrl_phase_line) |->
        bits_reg == 4'h8) else $error("address byte not eight bits");
    AST_DATA_LEN: assert property ($fell(ctrl_phase_line) |->
        bits_reg == 4'h8) else $error("data byte not eight bits");
    AST_BIT_CAP: assert property (bits_reg <= 4'h8)
        else $error("more than eight bits in a byte");
endmodule // ccr_link_props

// ===== codec_control_register_decoder_test.sv
/*
 Testbench: controller end and codec end joined by the link interface.
 Assumes both ends share ref_clk and sys_rst; requests go in one by one.
*/
`timescale 1ns/100ps
module codec_control_register_decoder_test
    import ccr_pkg::*;
;
    logic ref_clk;
    logic sys_rst;
    logic req_valid;
    logic [5:0] req_addr;
    logic [1:0] req_type;
    logic [7:0] req_data;
    logic req_ready;
    logic [1:0] ratio;
    logic [2:0] fmt;
    logic offset_en;
    logic [5:0] att;
    logic [4:0] bass;
    logic [2:0] treb;
    logic [1:0] emph;
    logic mute;
    logic m_hi;
    logic m_lo;
    logic [1:0] pwr;
    logic adc_on;
    logic dac_on;
    logic full;
    int miscompares;
    int total_checks;
    logic [5:0] vols [4] = '{6'h00, 6'h01, 6'h3d, 6'h3f};
    ccr_link_if link ();
    ccr_ctrl_end i_ccr_ctrl_end (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_addr(req_addr), .req_type(req_type),
        .req_data(req_data), .req_ready(req_ready), .link(link));
    ccr_codec_end i_ccr_codec_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link),
        .master_clock_ratio(ratio), .data_format(fmt), .offset_removal_enable(offset_en),
        .output_attenuation(att), .low_shelf_gain(bass), .high_shelf_gain(treb),
        .emphasis_curve(emph), .silence_enable(mute), .tone_set_select_hi(m_hi),
        .tone_set_select_lo(m_lo), .converter_power_gate(pwr), .adc_power_on(adc_on),
        .dac_power_on(dac_on), .full_attenuation(full));
    ccr_link_props i_ccr_link_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ctrl_shift_clock(link.ctrl_shift_clock), .ctrl_serial_line(link.ctrl_serial_line),
        .ctrl_phase_line(link.ctrl_phase_line));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic send(input logic [5:0] a, input logic [1:0] t, input logic [7:0] d);
        int n;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_addr = a;
        req_type = t;
        req_data = d;
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        // Ready falls after the take edge and rises once both bytes are out
        while (req_ready !== 1'b1 && n < 400)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400)
            chk("req_ready", 8'h01, 8'(req_ready));
    endtask
    task automatic conclude();
        $display("Checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #600000;
        miscompares++;
        conclude();
    end
    initial
    begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_addr = 6'h00;
        req_type = 2'h0;
        req_data = 8'h00;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk("att", 8'(CCR_RST_ATTEN), 8'(att));
        chk("pwr", 8'(CCR_RST_POWER), 8'(pwr));
        for (int i = 0; i < 8; i++)
        begin
            send(CCR_DEV_ADDR, CCR_XFER_STATUS, {2'b00, 2'(i % 3), 3'(i), 1'(i)});
            chk("ratio", 8'(i % 3), 8'(ratio));
            chk("fmt", 8'(i), 8'(fmt));
            chk("offset_en", 8'(i & 1), 8'(offset_en));
        end
        for (int i = 0; i < 4; i++)
        begin
            send(CCR_DEV_ADDR, CCR_XFER_DATA, {2'b00, vols[i]});
            chk("att", 8'(vols[i]), 8'(att));
            chk("full", 8'(vols[i] == 6'h3f), 8'(full));
        end
        send(CCR_DEV_ADDR, CCR_XFER_DATA, {2'b01, 4'ha, 2'h2});
        for (int m = 0; m < 4; m++)
        begin
            send(CCR_DEV_ADDR, CCR_XFER_DATA, {3'b100, 2'(m), 1'(m), 2'(m)});
            chk("emph", 8'(m), 8'(emph));
            chk("mute", 8'(m & 1), 8'(mute));
            chk("m_hi", 8'(m >> 1), 8'(m_hi));
            chk("m_lo", 8'(m & 1), 8'(m_lo));
            chk("bass", (m == 0) ? 8'd0 : (m == 3) ? 8'd20 : 8'd18, 8'(bass));
            chk("treb", (m == 0) ? 8'd0 : 8'd4, 8'(treb));
        end
        send(CCR_DEV_ADDR, CCR_XFER_DATA, {2'b01, 4'hf, 2'h3});
        chk("bass", 8'd24, 8'(bass));
        chk("treb", 8'd6, 8'(treb));
        for (int p = 0; p < 4; p++)
        begin
            send(CCR_DEV_ADDR, CCR_XFER_DATA, {6'b110000, 2'(p)});
            chk("pwr", 8'(p), 8'(pwr));
            chk("adc", 8'(p >> 1), 8'(adc_on));
            chk("dac", 8'(p & 1), 8'(dac_on));
        end
        // Malformed or misdirected bytes must leave the settings alone
        send(CCR_DEV_ADDR, CCR_XFER_DATA, 8'hc4);
        send(CCR_DEV_ADDR ^ 6'h01, CCR_XFER_DATA, 8'hc0);
        send(CCR_DEV_ADDR, 2'h1, 8'hc0);
        send(CCR_DEV_ADDR, 2'h3, 8'hc0);
        chk("pwr", 8'h03, 8'(pwr));
        send(CCR_DEV_ADDR, CCR_XFER_DATA, 8'ha4);
        chk("emph", 8'h03, 8'(emph));
        send(CCR_DEV_ADDR, CCR_XFER_STATUS, 8'h40);
        chk("ratio", 8'h01, 8'(ratio));
        chk("fmt", 8'h07, 8'(fmt));
        chk("att", 8'h3f, 8'(att));
        conclude();
    end
endmodule // codec_control_register_decoder_test
